// ### design/sdp_ram.sv
// port control logic and shared array of a synchronous dual-port ram
//
// Functional notes
// - input registers load only on the rising clock edge.
// - address, data, select and direction are registered before use.
// - output enable acts without clock; high floats the data pins.
// - write strobe is timed by clock edges, no write pulse input.
// - select sampled high deselects, floats pins, powers port down.
// - select and direction sampled low write registered data.
// - select low, direction high reads; pins driven while enable low.
// - a write begins at its sampling edge, ends at the next.
// - register enable low loads address and data; high holds them.
// - a stall holds registers by enable, never by clock gating.
// - minimum-cycle read-to-write with select low may store bad data.
// - a cross-port read sees a write once it reaches the array.
// - both ports are identical; either may write or read.
`timescale 1ns/100ps

// one port of the ram, as seen from its master:
// - select, direction and enable are sampled at every rising edge
// - a sampled write strobes the array during the following cycle,
//   so the word is in the array from the next edge on
// - a sampled read registers the array word at the next edge, and the
//   pins carry it for one cycle while output enable stays low
// - the output enable is never registered, so it can float the pins at
//   any time; a master that turns a bus round quickly should use it
// - a write sampled right behind a read still takes the pin value that
//   the master resolved, so a clashing read can leave a bad word
// - power-down follows the select sampled at the last edge, and the
//   pins let go one edge after that, when the last read data expires
// - nothing here arbitrates between the ports; see the array below
module sdp_port (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// master side
	input sdp_pkg::sdp_ctl_t ctl,
	// array side
	input wire logic [8:0] rd_word,
	output logic [11:0] rd_addr,
	output sdp_pkg::sdp_wr_t wr,
	// data pins and status
	output logic [8:0] pins_o,
	output logic pins_oe,
	output logic power_down
);
	logic [11:0] addr_ff;
	logic [8:0] write_data_ff;
	logic [8:0] read_data_ff;
	logic drive_ff;
	sdp_pkg::sdp_mode_t mode_ff;
	sdp_pkg::sdp_mode_t nxt_mode;

	// decode of the sampled select and direction
	always_comb begin
		if (ctl.ce_n) begin
			nxt_mode = sdp_pkg::SDP_IDLE;
		end else if (!ctl.rw) begin
			nxt_mode = sdp_pkg::SDP_WRITE;
		end else begin
			nxt_mode = sdp_pkg::SDP_READ;
		end
	end

	// control register: select and direction are never stalled
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			mode_ff <= sdp_pkg::SDP_IDLE;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// address and data registers, held by enable so the clock stays clean
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			addr_ff <= sdp_pkg::SDP_ADDR_RST;
			write_data_ff <= sdp_pkg::SDP_DATA_RST;
		end else if (!ctl.input_register_enable_n) begin
			addr_ff <= ctl.addr;
			write_data_ff <= ctl.write_data;
		end
	end

	// write lands at the edge after sampling, timed purely by the clock
	always_comb begin
		wr.en = (mode_ff == sdp_pkg::SDP_WRITE);
		wr.addr = addr_ff;
		wr.data = write_data_ff;
	end

	// if the master still drives stale pins here the array takes them
	assign rd_addr = addr_ff;

	// read data register and driver flag
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			read_data_ff <= sdp_pkg::SDP_DATA_RST;
			drive_ff <= 1'h0;
		end else begin
			if (mode_ff == sdp_pkg::SDP_READ) begin
				read_data_ff <= rd_word;
			end
			drive_ff <= (mode_ff == sdp_pkg::SDP_READ);
		end
	end

	// output enable is asynchronous: it gates the driver directly
	assign pins_oe = drive_ff & ~ctl.oe_n;
	assign pins_o = read_data_ff;
	assign power_down = (mode_ff == sdp_pkg::SDP_IDLE);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_wr_req;
		!ctl.ce_n && !ctl.rw;
	endsequence

	sequence s_rd_req;
		!ctl.ce_n && ctl.rw;
	endsequence

	// write request that also loads address and data
	sequence s_wr_load;
		!ctl.ce_n && !ctl.rw && !ctl.input_register_enable_n;
	endsequence

	// select sampled high
	sequence s_desel;
		ctl.ce_n;
	endsequence

	// input register enable high: address and data are stalled
	sequence s_stall;
		ctl.input_register_enable_n;
	endsequence

	// a write cycle opens at its sampling edge and closes one edge later
	a_write_begins: assert property (
		s_wr_req |=> wr.en
	) else $error("sampled write did not start a write cycle");

	a_write_ends: assert property (
		s_wr_req ##1 ctl.ce_n |=> !wr.en
	) else $error("write cycle did not end at the next edge");

	a_write_data: assert property (
		s_wr_load
		|=> wr.data == $past(ctl.write_data)
			&& wr.addr == $past(ctl.addr)
	) else $error("write used data other than the registered inputs");

	a_read_drive: assert property (
		s_rd_req ##2 !ctl.oe_n |-> pins_oe
	) else $error("read did not drive the data pins");

	a_read_data: assert property (
		(mode_ff == sdp_pkg::SDP_READ) |=> pins_o == $past(rd_word)
	) else $error("read data differs from the array word");

	a_oe_float: assert property (
		ctl.oe_n |-> !pins_oe
	) else $error("pins driven while output enable high");

	a_desel_float: assert property (
		s_desel |=> power_down ##1 !pins_oe
	) else $error("deselect did not power down and float");

	// a stalled edge keeps both registers whatever the pins carry
	a_addr_hold: assert property (
		s_stall
		|=> $stable(addr_ff) && $stable(write_data_ff)
	) else $error("input registers changed while stalled");

	// an enabled edge loads address and data from the pins
	a_addr_load: assert property (
		!ctl.input_register_enable_n
		|=> addr_ff == $past(ctl.addr)
	) else $error("address register did not load when enabled");

	a_data_load: assert property (
		!ctl.input_register_enable_n
		|=> write_data_ff == $past(ctl.write_data)
	) else $error("data register did not load when enabled");

	// the array strobe exists only behind a sampled write
	a_no_stray_write: assert property (
		ctl.ce_n || ctl.rw
		|=> !wr.en
	) else $error("array strobe without a sampled write");

	// a write behind a deselect leaves the pins floating
	a_write_floats: assert property (
		s_desel ##1 s_wr_req
		|=> !pins_oe
	) else $error("pins driven during a write cycle");

	// a selected port is awake from the next edge on
	a_select_awake: assert property (
		!ctl.ce_n
		|=> !power_down
	) else $error("selected port reported power-down");

	// a read takes its address from the input register
	a_read_addr: assert property (
		!ctl.ce_n && ctl.rw && !ctl.input_register_enable_n
		|=> rd_addr == $past(ctl.addr)
	) else $error("read address differs from the registered input");

	// read data stands until the next read replaces it
	a_pins_hold: assert property (
		mode_ff != sdp_pkg::SDP_READ
		|=> $stable(pins_o)
	) else $error("read data changed without a read");
endmodule

`timescale 1ns/100ps

// two identical ports share one array on one clock; the ports never
// wait for each other, so colliding writes are the masters' concern
module sdp_ram #(
	parameter int DEPTH = sdp_pkg::SDP_DEPTH
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// port a master inputs and data pins
	input sdp_pkg::sdp_ctl_t port_a_ctl,
	output logic [8:0] data_pins_a_o,
	output logic data_pins_a_oe,
	output logic power_down_a,
	// port b master inputs and data pins
	input sdp_pkg::sdp_ctl_t port_b_ctl,
	output logic [8:0] data_pins_b_o,
	output logic data_pins_b_oe,
	output logic power_down_b
);
	logic [8:0] mem [DEPTH];
	sdp_pkg::sdp_wr_t wr_a;
	sdp_pkg::sdp_wr_t wr_b;
	logic [11:0] rd_addr_a;
	logic [11:0] rd_addr_b;
	logic [8:0] rd_word_a;
	logic [8:0] rd_word_b;

	// both ports are the same module; only the array below favours port b, on a same-address double write
	sdp_port u_port_a (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ctl(port_a_ctl),
		.rd_word(rd_word_a),
		.rd_addr(rd_addr_a),
		.wr(wr_a),
		.pins_o(data_pins_a_o),
		.pins_oe(data_pins_a_oe),
		.power_down(power_down_a)
	);

	sdp_port u_port_b (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ctl(port_b_ctl),
		.rd_word(rd_word_b),
		.rd_addr(rd_addr_b),
		.wr(wr_b),
		.pins_o(data_pins_b_o),
		.pins_oe(data_pins_b_oe),
		.power_down(power_down_b)
	);

	// shared array; a same-address double write leaves port b's word
	always_ff @(posedge sys_clk) begin
		if (wr_a.en) begin
			mem[wr_a.addr] <= wr_a.data;
		end
		if (wr_b.en) begin
			mem[wr_b.addr] <= wr_b.data;
		end
	end

	// reads see the array as it stands, so a landed write is visible
	assign rd_word_a = mem[rd_addr_a];
	assign rd_word_b = mem[rd_addr_b];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	// a landed port a word is what either port reads next
	a_cross_visible: assert property (
		wr_a.en && !wr_b.en |=> mem[$past(wr_a.addr)] == $past(wr_a.data)
	) else $error("port a write not visible to port b");

	// port b's words land the same way, and it wins a collision
	a_cross_visible_b: assert property (
		wr_b.en |=> mem[$past(wr_b.addr)] == $past(wr_b.data)
	) else $error("port b write not visible to port a");
endmodule

// ### inc/sdp_pkg.sv
// shared constants and carrier types for the dual-port ram port logic
package sdp_pkg;
	// array geometry
	localparam int SDP_ADDR_W = 12;
	localparam int SDP_DATA_W = 9;
	localparam int SDP_DEPTH = 4096;

	// reset values of the per-port input registers
	localparam logic [11:0] SDP_ADDR_RST = 12'h000;
	localparam logic [8:0] SDP_DATA_RST = 9'h000;
	localparam logic SDP_CE_N_RST = 1'h1;
	localparam logic SDP_RW_RST = 1'h1;

	// cycle that a sampled write waits before it hits the array
	localparam int SDP_WR_LAT = 1;

	// mode a port is in after its last rising edge
	typedef enum logic [1:0] {
		SDP_IDLE = 2'b00,
		SDP_WRITE = 2'b01,
		SDP_READ = 2'b10
	} sdp_mode_t;

	// master-side inputs of one port, all sampled except oe_n
	typedef struct packed {
		logic ce_n;
		logic rw;
		logic oe_n;
		logic input_register_enable_n;
		logic [11:0] addr;
		logic [8:0] write_data;
	} sdp_ctl_t;

	// write request from one port to the shared array
	typedef struct packed {
		logic en;
		logic [11:0] addr;
		logic [8:0] data;
	} sdp_wr_t;
endpackage

// ### verification/sdp_master.sv
// bus master model for one port of the dual-port ram
`timescale 1ns/100ps
module sdp_master (
	// clock
	input wire logic sys_clk,
	// port inputs and data pins
	output sdp_pkg::sdp_ctl_t ctl,
	input wire logic [8:0] pins_o,
	input wire logic pins_oe
);
	// idle: deselected, outputs off, input registers loading
	initial ctl = '{1'b1, 1'b1, 1'b1, 1'b0, 12'h000, 9'h000};

	// one access, then deselect so a read never runs into a write
	task automatic op(input logic rw, oe_n, ien_n, input logic [11:0] a,
		input logic [8:0] d, output logic [8:0] q, output logic oe);
		@(posedge sys_clk);
		ctl <= '{1'b0, rw, oe_n, ien_n, a, d};
		@(posedge sys_clk);
		ctl.ce_n <= 1'b1; // no write follows at min cycle
		ctl.write_data <= ~d; // released data line shows the inverse
		@(posedge sys_clk);
		#1;
		q = pins_o;
		oe = pins_oe;
	endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the dual-port ram port logic
`timescale 1ns/100ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	int n_errors = 0;
	int checked = 0;
	sdp_pkg::sdp_ctl_t ca, cb;
	logic [8:0] pa, pb, q;
	logic oa, ob, pda, pdb, oe;

	sdp_ram dut (.sys_clk(sys_clk), .rstn(rstn), .port_a_ctl(ca),
		.data_pins_a_o(pa), .data_pins_a_oe(oa), .power_down_a(pda),
		.port_b_ctl(cb), .data_pins_b_o(pb), .data_pins_b_oe(ob),
		.power_down_b(pdb));
	sdp_master ma (.sys_clk(sys_clk), .ctl(ca), .pins_o(pa), .pins_oe(oa));
	sdp_master mb (.sys_clk(sys_clk), .ctl(cb), .pins_o(pb), .pins_oe(ob));

	// 100 mhz clock
	initial forever #5 sys_clk = ~sys_clk;

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// write then read back on port a, array corners included
	task automatic t_rw();
		logic [11:0] a[3] = '{12'h000, 12'hfff, 12'h5a5};
		logic [8:0] d[3] = '{9'h1ff, 9'h000, 9'h0a5};
		for (int i = 0; i < 3; i++) begin
			ma.op(1'b0, 1'b0, 1'b0, a[i], d[i], q, oe);
			ma.op(1'b1, 1'b0, 1'b0, a[i], 9'h000, q, oe);
			chk(q, d[i]);
			chk({8'h00, oe}, 9'h001);
			chk({8'h00, pda}, 9'h001);
		end
		$display("t_rw done");
	endtask

	// concurrent writes, then each port reads the other's word
	task automatic t_cross();
		fork
			ma.op(1'b0, 1'b0, 1'b0, 12'h010, 9'h111, q, oe);
			mb.op(1'b0, 1'b0, 1'b0, 12'h020, 9'h122, q, oe);
		join
		mb.op(1'b1, 1'b0, 1'b0, 12'h010, 9'h000, q, oe);
		chk(q, 9'h111);
		chk({8'h00, oe}, 9'h001);
		ma.op(1'b1, 1'b0, 1'b0, 12'h020, 9'h000, q, oe);
		chk(q, 9'h122);
		$display("t_cross done");
	endtask

	// read with outputs disabled, then a read under a stalled register
	task automatic t_oe_stall();
		ma.op(1'b1, 1'b1, 1'b0, 12'h010, 9'h000, q, oe);
		chk({8'h00, oe}, 9'h000);
		mb.op(1'b0, 1'b0, 1'b0, 12'h030, 9'h133, q, oe);
		mb.op(1'b1, 1'b0, 1'b1, 12'h020, 9'h000, q, oe);
		chk(q, 9'h133);
		chk({8'h00, pdb}, 9'h001);
		$display("t_oe_stall done");
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		chk({7'h00, pda, oa}, 9'h002);
		rstn <= 1'b1;
		t_rw();
		t_cross();
		t_oe_stall();
		results();
	end

	// watchdog
	initial begin
		#20000;
		n_errors++;
		results();
	end
endmodule
